// file: bfp_defs.svh
/*
 * Constants of the bidirectional queue port slice: sizes, register
 * offsets, field positions, reset values and sequence counts.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef BFP_DEFS_SVH
`define BFP_DEFS_SVH

// Queue geometry
`define BFP_DW 36
`define BFP_AW 6
`define BFP_CW 7
`define BFP_DEPTH 7'h40

// Almost-flag offsets chosen by the two offset select pins
`define BFP_ALMOST_OFS0 7'h04
`define BFP_ALMOST_OFS1 7'h08
`define BFP_ALMOST_OFS2 7'h10
`define BFP_ALMOST_OFS3 7'h20

// Reset sequence
`define BFP_RST_EDGES 3'h4
`define BFP_REL_DONE 2'h2
`define BFP_FLAGS_RESET 4'h4

// Register map (byte addresses)
`define BFP_ADDR_W 8
`define BFP_REG_STATUS 8'h00
`define BFP_REG_MASK 8'h04
`define BFP_REG_CTRL 8'h08
`define BFP_REG_FLAGS 8'h0c

// Event bits of status and mask
`define BFP_EV_W 4
`define BFP_EV_MAIL1 0
`define BFP_EV_MAIL2 1
`define BFP_EV_FULL1 2
`define BFP_EV_FULL2 3

// Control bits
`define BFP_CTRL_FLUSH 0

// Bus responses
`define BFP_RESP_OKAY 2'h0
`define BFP_RESP_DECERR 2'h3

`endif

// file: bfp_pkg.sv
/*
 * Types shared by the queue port slice: port request bundle, flag
 * bundle and the registered state of the top module.
 * Assumes bfp_defs.svh is on the include path.
 */
`include "bfp_defs.svh"

package bfp_pkg;

    typedef struct packed {
        logic transfer_gate;
        logic dir_select;
        logic mail_select;
        logic parity_gen;
        logic [`BFP_DW-1:0] din;
    } bfp_port_in_t;

    // All active low
    typedef struct packed {
        logic full_n;
        logic afull_n;
        logic empty_n;
        logic aempty_n;
    } bfp_flags_t;

    typedef struct packed {
        logic [`BFP_CW-1:0] cnt1;
        logic [`BFP_CW-1:0] cnt2;
        logic [`BFP_AW-1:0] wp1;
        logic [`BFP_AW-1:0] rp1;
        logic [`BFP_AW-1:0] wp2;
        logic [`BFP_AW-1:0] rp2;
        logic [`BFP_DW-1:0] mail1;
        logic [`BFP_DW-1:0] mail2;
        logic [`BFP_DW-1:0] a_dout;
        logic [`BFP_DW-1:0] b_dout;
        logic mail1_full_flag_n_n;
        logic mail2_full_flag_n_n;
        bfp_flags_t fa;
        bfp_flags_t fb;
        logic [1:0] ofs_sel;
        logic rst_prev;
        logic [2:0] rst_cnt;
        logic [1:0] rel_cnt;
        logic [`BFP_EV_W-1:0] irq_stat;
        logic [`BFP_EV_W-1:0] irq_mask;
        logic flush;
        logic aw_hold;
        logic w_hold;
        logic [`BFP_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bfp_state_t;

endpackage : bfp_pkg

// file: bfp_mem.sv
/*
 * Queue storage: one write port, one read port with registered data.
 * Assumes the caller never writes a full queue.
 */
`timescale 1ns/10ps
`include "bfp_defs.svh"

module bfp_mem
    import bfp_pkg::*;
#(
    parameter int DW = `BFP_DW,
    parameter int AW = `BFP_AW
) (
    // Clock
    input wire logic aclk,
    // Write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read side
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule : bfp_mem

// file: bfp_parity.sv
/*
 * Read-side parity generator: replaces the top bit of each 9-bit byte.
 * Assumes a purely combinational use ahead of an output register.
 */
`timescale 1ns/10ps
`include "bfp_defs.svh"

module bfp_parity
    import bfp_pkg::*;
(
    // Control
    input wire logic gen,
    input wire logic odd,
    // Data
    input wire logic [`BFP_DW-1:0] din,
    output logic [`BFP_DW-1:0] dout
);

    always_comb begin
        dout = din;
        if (gen) begin
            for (int i = 0; i < 4; i++) begin
                dout[9*i+8] = (^din[9*i +: 8]) ^ odd;
            end
        end
    end

endmodule : bfp_parity

// file: bfp_top.sv
/*
 * Port control slice of a two-way clocked queue: two 64 x 36 queues,
 * two mailboxes, read parity generation, reset sequence and flags,
 * plus an AXI4-Lite register slave with a masked interrupt.
 * Assumes both ports and the bus run on aclk with synchronous inputs.
 */
// Summary of operation
// - A port A read with parity generation high gets generated parity.
// - Port A parity sits in bits 8, 17, 26 and 35 of its four bytes.
// - A port B read with parity generation high gets generated parity.
// - Port B parity sits in bits 8, 17, 26 and 35 of its four bytes.
// - Reset raises almost-full and mail flags, lowers empty/almost/full.
// - Release of the device reset latches the two offset select pins.
// - On an enabled port A edge, direction high writes and low reads.
// - Port A data outputs are undriven while its direction is high.
// - On an enabled port B edge, direction high writes and low reads.
// - Port B data outputs are undriven while its direction is high.
// - Odd/even select high means odd parity, low means even parity.
// - Mail select high routes a transfer to the mailbox, not the queue.
// - Each full flag rises on the second edge after reset release.
`timescale 1ns/10ps
`include "bfp_defs.svh"

module bfp_top
    import bfp_pkg::*;
(
    // System
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [`BFP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`BFP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device control
    input wire logic port_reset_n,
    input wire logic odd_even,
    input wire logic offset_sel_0,
    input wire logic offset_sel_1,
    // Port A
    input wire bfp_port_in_t port_a,
    output logic [`BFP_DW-1:0] port_a_dout,
    output logic port_a_dout_oe_n,
    // Port B
    input wire bfp_port_in_t port_b,
    output logic [`BFP_DW-1:0] port_b_dout,
    output logic port_b_dout_oe_n,
    // Flags, all active low
    output logic full_flag_a_n,
    output logic almost_full_a_n,
    output logic empty_flag_a_n,
    output logic almost_empty_a_n,
    output logic full_flag_b_n,
    output logic almost_full_b_n,
    output logic empty_flag_b_n,
    output logic almost_empty_b_n,
    output logic mail1_full_flag_n,
    output logic mail2_full_flag_n,
    // Interrupt
    output logic irq
);

    bfp_state_t s;
    bfp_state_t n;
    logic live;
    logic clear;
    logic a_wr;
    logic a_rd;
    logic b_wr;
    logic b_rd;
    logic w1;
    logic r1;
    logic w2;
    logic r2;
    logic m1w;
    logic m1r;
    logic m2w;
    logic m2r;
    logic [`BFP_CW-1:0] ofs;
    logic [`BFP_DW-1:0] mem1_rdata;
    logic [`BFP_DW-1:0] mem2_rdata;
    logic [`BFP_DW-1:0] a_src;
    logic [`BFP_DW-1:0] b_src;
    logic [`BFP_DW-1:0] par_a_out;
    logic [`BFP_DW-1:0] par_b_out;
    logic [31:0] flags_word;

    function automatic logic [`BFP_CW-1:0] q_count(
        input logic [`BFP_CW-1:0] c, input logic w, input logic r,
        input logic clr);
        if (clr) begin
            q_count = '0;
        end else begin
            q_count = c + {6'h00, w} - {6'h00, r};
        end
    endfunction : q_count

    function automatic logic [`BFP_AW-1:0] ptr_next(
        input logic [`BFP_AW-1:0] p, input logic inc, input logic clr);
        if (clr) begin
            ptr_next = '0;
        end else begin
            ptr_next = p + {5'h00, inc};
        end
    endfunction : ptr_next

    function automatic logic [`BFP_CW-1:0] ofs_value(input logic [1:0] sel);
        case (sel)
            2'h0: ofs_value = `BFP_ALMOST_OFS0;
            2'h1: ofs_value = `BFP_ALMOST_OFS1;
            2'h2: ofs_value = `BFP_ALMOST_OFS2;
            default: ofs_value = `BFP_ALMOST_OFS3;
        endcase
    endfunction : ofs_value

    // Transfers only after the release sequence has finished
    assign live = port_reset_n && s.rel_cnt == `BFP_REL_DONE;
    assign clear = !port_reset_n || s.flush;
    assign a_wr = live && port_a.transfer_gate && port_a.dir_select;
    assign a_rd = live && port_a.transfer_gate && !port_a.dir_select;
    assign b_wr = live && port_b.transfer_gate && port_b.dir_select;
    assign b_rd = live && port_b.transfer_gate && !port_b.dir_select;
    assign w1 = a_wr && !port_a.mail_select && s.fa.full_n;
    assign m1w = a_wr && port_a.mail_select && s.mail1_full_flag_n_n;
    assign r2 = a_rd && !port_a.mail_select && s.fa.empty_n;
    assign m2r = a_rd && port_a.mail_select;
    assign w2 = b_wr && !port_b.mail_select && s.fb.full_n;
    assign m2w = b_wr && port_b.mail_select && s.mail2_full_flag_n_n;
    assign r1 = b_rd && !port_b.mail_select && s.fb.empty_n;
    assign m1r = b_rd && port_b.mail_select;
    assign ofs = ofs_value(s.ofs_sel);
    assign a_src = port_a.mail_select ? s.mail2 : mem2_rdata;
    assign b_src = port_b.mail_select ? s.mail1 : mem1_rdata;

    bfp_mem u_queue1 (
        .aclk(aclk),
        .wr_en(w1),
        .wr_addr(s.wp1),
        .wr_data(port_a.din),
        .rd_addr(ptr_next(s.rp1, r1, clear)),
        .rd_data(mem1_rdata)
    );

    bfp_mem u_queue2 (
        .aclk(aclk),
        .wr_en(w2),
        .wr_addr(s.wp2),
        .wr_data(port_b.din),
        .rd_addr(ptr_next(s.rp2, r2, clear)),
        .rd_data(mem2_rdata)
    );

    bfp_parity u_par_a (
        .gen(port_a.parity_gen),
        .odd(odd_even),
        .din(a_src),
        .dout(par_a_out)
    );

    bfp_parity u_par_b (
        .gen(port_b.parity_gen),
        .odd(odd_even),
        .din(b_src),
        .dout(par_b_out)
    );

    assign flags_word = {1'b0, s.cnt2, 1'b0, s.cnt1, 3'h0,
        s.rst_cnt == `BFP_RST_EDGES, s.ofs_sel, s.mail2_full_flag_n_n, s.mail1_full_flag_n_n,
        s.fb, s.fa};

    always_comb begin
        logic [`BFP_EV_W-1:0] ev;
        logic [`BFP_EV_W-1:0] clr;
        ev = '0;
        clr = '0;
        n = s;
        n.flush = 1'b0;
        // Queues
        n.cnt1 = q_count(s.cnt1, w1, r1, clear);
        n.cnt2 = q_count(s.cnt2, w2, r2, clear);
        n.wp1 = ptr_next(s.wp1, w1, clear);
        n.rp1 = ptr_next(s.rp1, r1, clear);
        n.wp2 = ptr_next(s.wp2, w2, clear);
        n.rp2 = ptr_next(s.rp2, r2, clear);
        // Mailboxes, a write beats a read in the same cycle
        if (m1r) begin
            n.mail1_full_flag_n_n = 1'b1;
        end
        if (m1w) begin
            n.mail1 = port_a.din;
            n.mail1_full_flag_n_n = 1'b0;
        end
        if (m2r) begin
            n.mail2_full_flag_n_n = 1'b1;
        end
        if (m2w) begin
            n.mail2 = port_b.din;
            n.mail2_full_flag_n_n = 1'b0;
        end
        // Read data with optional parity
        if (r2 || m2r) begin
            n.a_dout = par_a_out;
        end
        if (r1 || m1r) begin
            n.b_dout = par_b_out;
        end
        // Flags; empty waits one cycle for the read register
        n.fa.full_n = s.rel_cnt != 2'h0 && n.cnt1 != `BFP_DEPTH;
        n.fb.full_n = s.rel_cnt != 2'h0 && n.cnt2 != `BFP_DEPTH;
        n.fa.afull_n = n.cnt1 < (`BFP_DEPTH - ofs);
        n.fb.afull_n = n.cnt2 < (`BFP_DEPTH - ofs);
        n.fa.empty_n = n.cnt2 != 7'h00 && s.cnt2 != 7'h00;
        n.fb.empty_n = n.cnt1 != 7'h00 && s.cnt1 != 7'h00;
        n.fa.aempty_n = n.cnt2 > ofs;
        n.fb.aempty_n = n.cnt1 > ofs;
        // Device reset sequence
        n.rst_prev = port_reset_n;
        if (!port_reset_n) begin
            n.fa = bfp_flags_t'(`BFP_FLAGS_RESET);
            n.fb = bfp_flags_t'(`BFP_FLAGS_RESET);
            n.mail1_full_flag_n_n = 1'b1;
            n.mail2_full_flag_n_n = 1'b1;
            n.rel_cnt = 2'h0;
            if (s.rst_prev) begin
                n.rst_cnt = 3'h1;
            end else if (s.rst_cnt != `BFP_RST_EDGES) begin
                n.rst_cnt = s.rst_cnt + 3'h1;
            end
        end else begin
            if (!s.rst_prev) begin
                n.ofs_sel = {offset_sel_1, offset_sel_0};
            end
            if (s.rel_cnt != `BFP_REL_DONE) begin
                n.rel_cnt = s.rel_cnt + 2'h1;
            end
        end
        // Events
        ev[`BFP_EV_MAIL1] = m1w;
        ev[`BFP_EV_MAIL2] = m2w;
        ev[`BFP_EV_FULL1] = port_reset_n && s.fa.full_n && !n.fa.full_n;
        ev[`BFP_EV_FULL2] = port_reset_n && s.fb.full_n && !n.fb.full_n;
        // Bus write
        if (s_axi_awvalid && !s.aw_hold && !s.bvalid) begin
            n.aw_hold = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_hold && !s.bvalid) begin
            n.w_hold = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_hold && s.w_hold) begin
            n.aw_hold = 1'b0;
            n.w_hold = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `BFP_RESP_OKAY;
            if (s.awaddr == `BFP_REG_STATUS) begin
                clr = s.wstrb0 ? s.wdata[`BFP_EV_W-1:0] : '0;
            end else if (s.awaddr == `BFP_REG_MASK) begin
                if (s.wstrb0) begin
                    n.irq_mask = s.wdata[`BFP_EV_W-1:0];
                end
            end else if (s.awaddr == `BFP_REG_CTRL) begin
                n.flush = s.wstrb0 && s.wdata[`BFP_CTRL_FLUSH];
            end else if (s.awaddr != `BFP_REG_FLAGS) begin
                n.bresp = `BFP_RESP_DECERR;
            end
        end
        // Set wins over clear
        n.irq_stat = (s.irq_stat & ~clr) | ev;
        // Bus read
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp = `BFP_RESP_OKAY;
            n.rdata = '0;
            if (s_axi_araddr == `BFP_REG_STATUS) begin
                n.rdata[`BFP_EV_W-1:0] = s.irq_stat;
            end else if (s_axi_araddr == `BFP_REG_MASK) begin
                n.rdata[`BFP_EV_W-1:0] = s.irq_mask;
            end else if (s_axi_araddr == `BFP_REG_CTRL) begin
                n.rdata[`BFP_CTRL_FLUSH] = s.flush;
            end else if (s_axi_araddr == `BFP_REG_FLAGS) begin
                n.rdata = flags_word;
            end else begin
                n.rresp = `BFP_RESP_DECERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.fa <= bfp_flags_t'(`BFP_FLAGS_RESET);
            s.fb <= bfp_flags_t'(`BFP_FLAGS_RESET);
            s.mail1_full_flag_n_n <= 1'b1;
            s.mail2_full_flag_n_n <= 1'b1;
            s.rst_cnt <= `BFP_RST_EDGES;
        end else begin
            s <= n;
        end
    end

    // Outputs
    assign port_a_dout = s.a_dout;
    assign port_b_dout = s.b_dout;
    assign port_a_dout_oe_n = port_a.dir_select;
    assign port_b_dout_oe_n = port_b.dir_select;
    assign full_flag_a_n = s.fa.full_n;
    assign almost_full_a_n = s.fa.afull_n;
    assign empty_flag_a_n = s.fa.empty_n;
    assign almost_empty_a_n = s.fa.aempty_n;
    assign full_flag_b_n = s.fb.full_n;
    assign almost_full_b_n = s.fb.afull_n;
    assign empty_flag_b_n = s.fb.empty_n;
    assign almost_empty_b_n = s.fb.aempty_n;
    assign mail1_full_flag_n = s.mail1_full_flag_n_n;
    assign mail2_full_flag_n = s.mail2_full_flag_n_n;
    assign irq = |(s.irq_stat & s.irq_mask);
    assign s_axi_awready = !s.aw_hold && !s.bvalid;
    assign s_axi_wready = !s.w_hold && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_par_gen_a: assert property (
        (r2 || m2r) && port_a.parity_gen |=>
        (^port_a_dout[8:0]) == $past(odd_even) &&
        (^port_a_dout[17:9]) == $past(odd_even) &&
        (^port_a_dout[26:18]) == $past(odd_even) &&
        (^port_a_dout[35:27]) == $past(odd_even))
        else $error("port A generated parity wrong");

    chk_par_gen_b: assert property (
        (r1 || m1r) && port_b.parity_gen |=>
        (^port_b_dout[8:0]) == $past(odd_even) &&
        (^port_b_dout[17:9]) == $past(odd_even) &&
        (^port_b_dout[26:18]) == $past(odd_even) &&
        (^port_b_dout[35:27]) == $past(odd_even))
        else $error("port B generated parity wrong");

    chk_mail_data_a: assert property (
        m2r |=> port_a_dout[7:0] == $past(s.mail2[7:0]) &&
        port_a_dout[16:9] == $past(s.mail2[16:9]) &&
        port_a_dout[25:18] == $past(s.mail2[25:18]) &&
        port_a_dout[34:27] == $past(s.mail2[34:27]))
        else $error("port A mail data bits altered");

    chk_dir_hiz_a: assert property (
        port_a.dir_select |-> port_a_dout_oe_n ##1 $stable(port_a_dout))
        else $error("port A driven or changed while writing");

    chk_dir_hiz_b: assert property (
        port_b.dir_select |-> port_b_dout_oe_n ##1 $stable(port_b_dout))
        else $error("port B driven or changed while writing");

    chk_dir_write_a: assert property (
        w1 && !r1 |=> s.cnt1 == $past(s.cnt1) + 7'h01)
        else $error("port A write not stored");

    chk_dir_write_b: assert property (
        w2 && !r2 |=> s.cnt2 == $past(s.cnt2) + 7'h01)
        else $error("port B write not stored");

    chk_reset_flags: assert property (
        !port_reset_n |=> !full_flag_a_n && !full_flag_b_n &&
        !empty_flag_a_n && !empty_flag_b_n && !almost_empty_a_n &&
        !almost_empty_b_n && almost_full_a_n && almost_full_b_n &&
        mail1_full_flag_n && mail2_full_flag_n)
        else $error("flags wrong during device reset");

    chk_offset_latch: assert property (
        port_reset_n && !s.rst_prev |=>
        s.ofs_sel == $past({offset_sel_1, offset_sel_0}))
        else $error("offset select not latched at release");

    chk_full_release: assert property (
        port_reset_n && !s.rst_prev ##1 port_reset_n |->
        !full_flag_a_n ##1 full_flag_a_n && full_flag_b_n)
        else $error("full flags not high on second edge");

    chk_queue_clear: assert property (
        !port_reset_n |=> s.cnt1 == 7'h00 && s.cnt2 == 7'h00 &&
        s.wp1 == s.rp1 && s.wp2 == s.rp2)
        else $error("queues not emptied by reset");

endmodule : bfp_top

// file: bfp_port_host.sv
/* Port controller model: one transfer per call on one queue port.
 * Assumes aclk serves as the port clock. */
`timescale 1ns/10ps

module bfp_port_host
    import bfp_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Port
    output bfp_port_in_t port,
    input wire logic [35:0] dout,
    input wire logic dout_oe_n
);
    initial port = '0;

    task automatic xfer(input logic dir, input logic mail, input logic pg,
        input logic [35:0] d, output logic [35:0] q, output logic oe_n);
        @(posedge aclk);
        port <= '{1'b1, dir, mail, pg, d};
        @(negedge aclk);
        oe_n = dout_oe_n;
        @(posedge aclk);
        port.transfer_gate <= 1'b0;
        // Released data lines do not keep their last value
        port.din <= ~d;
        @(negedge aclk);
        q = dout;
    endtask : xfer
endmodule : bfp_port_host

// file: test_bfp_top.sv
/* Self-checking bench of the queue port slice.
 * Assumes bfp_port_host models the controllers of both ports. */
`timescale 1ns/10ps
`include "bfp_defs.svh"

module test_bfp_top
    import bfp_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic port_reset_n = 1'b0;
    logic odd_even = 1'b0;
    logic offset_sel_0 = 1'b0;
    logic offset_sel_1 = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    bfp_port_in_t port_a, port_b;
    logic [35:0] port_a_dout, port_b_dout, q;
    logic port_a_dout_oe_n, port_b_dout_oe_n, oe;
    logic full_flag_a_n, almost_full_a_n, empty_flag_a_n, almost_empty_a_n;
    logic full_flag_b_n, almost_full_b_n, empty_flag_b_n, almost_empty_b_n;
    logic mail1_full_flag_n, mail2_full_flag_n;
    int fails = 0;
    int check_count = 0;

    always #5 aclk = ~aclk;

    bfp_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_reset_n,
        .odd_even, .offset_sel_0, .offset_sel_1, .port_a, .port_a_dout,
        .port_a_dout_oe_n, .port_b, .port_b_dout, .port_b_dout_oe_n,
        .full_flag_a_n, .almost_full_a_n, .empty_flag_a_n,
        .almost_empty_a_n, .full_flag_b_n, .almost_full_b_n,
        .empty_flag_b_n, .almost_empty_b_n, .mail1_full_flag_n,
        .mail2_full_flag_n, .irq);
    bfp_port_host host_a (.aclk, .port(port_a), .dout(port_a_dout),
        .dout_oe_n(port_a_dout_oe_n));
    bfp_port_host host_b (.aclk, .port(port_b), .dout(port_b_dout),
        .dout_oe_n(port_b_dout_oe_n));

    function automatic logic [35:0] par(input logic [35:0] d,
        input logic odd);
        logic [35:0] r;
        r = d;
        for (int i = 0; i < 4; i++) begin
            r[9*i+8] = (^d[9*i+:8]) ^ odd;
        end
        return r;
    endfunction : par

    task automatic chk(input logic [35:0] got, input logic [35:0] exp,
        input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        int n;
        b = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b && n < 50) begin
            @(negedge aclk);
            aw = s_axi_awready && s_axi_awvalid;
            w = s_axi_wready && s_axi_wvalid;
            b = s_axi_bvalid === 1'b1;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        if (!b) begin
            fails++;
            $display("MISMATCH %0t write answer timed out", $time);
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        logic ar, v;
        int n;
        v = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v && n < 50) begin
            @(negedge aclk);
            ar = s_axi_arready && s_axi_arvalid;
            v = s_axi_rvalid === 1'b1;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        if (!v) begin
            fails++;
            $display("MISMATCH %0t read answer timed out", $time);
        end
    endtask : axi_rd

    task automatic t_reset;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk({26'h0, full_flag_a_n, almost_full_a_n, empty_flag_a_n,
            almost_empty_a_n, full_flag_b_n, almost_full_b_n,
            empty_flag_b_n, almost_empty_b_n, mail1_full_flag_n,
            mail2_full_flag_n}, 36'h113, "reset flags");
        @(posedge aclk);
        aresetn <= 1'b1;
        port_reset_n <= 1'b1;
        @(posedge aclk);
        @(negedge aclk);
        chk({34'h0, full_flag_a_n, full_flag_b_n}, 36'h0, "full early");
        @(negedge aclk);
        chk({34'h0, full_flag_a_n, full_flag_b_n}, 36'h3, "full late");
    endtask : t_reset

    task automatic t_regs;
        axi_rd(`BFP_REG_MASK);
        chk({4'h0, rd}, 36'h0, "mask reset");
        axi_rd(`BFP_REG_FLAGS);
        chk({33'h0, rd[12:10]}, 36'h6, "offset latch");
        axi_rd(8'h10);
        chk({34'h0, rs}, {34'h0, `BFP_RESP_DECERR}, "unmapped");
        axi_wr(8'h10, 32'h0);
        chk({34'h0, rs}, {34'h0, `BFP_RESP_DECERR}, "unmapped write");
    endtask : t_regs

    task automatic t_queue;
        @(posedge aclk);
        odd_even <= 1'b1;
        host_a.xfer(1'b1, 1'b0, 1'b0, 36'h1_2345_6789, q, oe);
        chk({35'h0, oe}, 36'h1, "a write oe");
        host_a.xfer(1'b1, 1'b0, 1'b0, 36'h0, q, oe);
        repeat (10) if (empty_flag_b_n !== 1'b1) @(negedge aclk);
        host_b.xfer(1'b0, 1'b0, 1'b0, 36'h0, q, oe);
        chk(q, 36'h1_2345_6789, "b read");
        chk({35'h0, oe}, 36'h0, "b read oe");
        host_b.xfer(1'b0, 1'b0, 1'b1, 36'h0, q, oe);
        chk(q, par(36'h0, 1'b1), "b parity");
        @(posedge aclk);
        odd_even <= 1'b0;
        host_b.xfer(1'b1, 1'b0, 1'b0, 36'h8_1c0e_0703, q, oe);
        chk({35'h0, oe}, 36'h1, "b write oe");
        repeat (10) if (empty_flag_a_n !== 1'b1) @(negedge aclk);
        host_a.xfer(1'b0, 1'b0, 1'b1, 36'h0, q, oe);
        chk(q, par(36'h8_1c0e_0703, 1'b0), "a parity");
        chk({34'h0, empty_flag_a_n, empty_flag_b_n}, 36'h0, "drained");
    endtask : t_queue

    task automatic t_mail;
        host_a.xfer(1'b1, 1'b1, 1'b0, 36'h5_a5a5_a5a5, q, oe);
        chk({34'h0, mail1_full_flag_n, irq}, 36'h0, "mail held");
        axi_rd(`BFP_REG_STATUS);
        chk({4'h0, rd}, 36'h1, "status");
        axi_wr(`BFP_REG_MASK, 32'h1);
        chk({35'h0, irq}, 36'h1, "irq on");
        axi_wr(`BFP_REG_STATUS, 32'h1);
        chk({35'h0, irq}, 36'h0, "irq cleared");
        host_b.xfer(1'b0, 1'b1, 1'b0, 36'h0, q, oe);
        chk(q, 36'h5_a5a5_a5a5, "mail data");
        chk({35'h0, mail1_full_flag_n}, 36'h1, "mail taken");
        @(posedge aclk);
        odd_even <= 1'b1;
        host_b.xfer(1'b1, 1'b1, 1'b0, 36'h0_0000_00ff, q, oe);
        chk({35'h0, mail2_full_flag_n}, 36'h0, "mail2 held");
        host_a.xfer(1'b0, 1'b1, 1'b1, 36'h0, q, oe);
        chk(q, par(36'h0_0000_00ff, 1'b1), "mail2 parity");
        chk({35'h0, mail2_full_flag_n}, 36'h1, "mail2 taken");
    endtask : t_mail

    task automatic t_rerun;
        host_a.xfer(1'b1, 1'b0, 1'b0, 36'h0, q, oe);
        axi_wr(`BFP_REG_CTRL, 32'h1);
        axi_rd(`BFP_REG_FLAGS);
        chk({29'h0, rd[22:16]}, 36'h0, "flush");
        host_a.xfer(1'b1, 1'b0, 1'b0, 36'h0, q, oe);
        @(posedge aclk);
        port_reset_n <= 1'b0;
        offset_sel_0 <= 1'b1;
        offset_sel_1 <= 1'b0;
        repeat (4) @(posedge aclk);
        port_reset_n <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_rd(`BFP_REG_FLAGS);
        chk({4'h0, rd}, 36'h17cc, "rerun flags");
    endtask : t_rerun

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #100us;
        fails++;
        conclude();
    end

    initial begin
        t_reset();
        t_regs();
        t_queue();
        t_mail();
        t_rerun();
        conclude();
    end
endmodule : test_bfp_top
